// ### inc/rcc_pkg.sv
/*
 * Constants, types and register map of the command classifier.
 * Assumes an APB master on pclk and a word decoder on the same clock.
 */
// Summary of operation
// R01: Loopback transmit word, host read-write, master reset only.
// R02: Loopback receive word, read-only, loaded by loopback.
// R03: Valid word needs sync, Manchester, count, odd parity.
// R04: Command sync marks commands; keep sixteen data bits.
// R05: Accept own address or broadcast address 31.
// R06: Broadcast disable makes address 31 invalid, no response.
// R07: Subaddress 1..30: direction bit, count zero means 32.
// R08: Subaddress 0 or 31: low bits are mode code.
// R09: Mode codes 16..31 carry one data word.
// R10: Mode codes 0..15 need transmit bit set.
// R11: Twenty-two combinations are undefined mode commands.
// R12: Undefined-invalid bit drops undefined mode commands silently.
// R13: Legal entry: clear status, in-form response, status update.
// R14: Illegal entry: status only with Message Error.
// R15: Reserved mode codes follow their table entry.
// R16: Table entries read zero after master reset.
// R17: Mode data words use fixed per-code locations.
// R18: Each subaddress direction has own descriptor block.
// R19: RT-RT pair: receive then transmit, never 31.
// R20: Pair with mode subaddress is ignored, no status.
// R21: Own first word: RT-RT receive, flag set.
// R22: Own second word only: ordinary transmit.
// R23: Analog select low: digital loopback, bus untouched.
// R24: Digital loopback encodes, decodes, stores received word.
// R25: Illegal valid command raises message error condition.
package rcc_pkg;
    // Printed register indices; byte address is four times these.
    localparam logic [7:0] IDX_LB_TX = 8'h18;
    localparam logic [7:0] IDX_LB_RX = 8'h19;
    localparam logic [7:0] IDX_CFG = 8'h20;
    localparam logic [7:0] IDX_ILL_SEL = 8'h21;
    localparam logic [7:0] IDX_ILL_DAT = 8'h22;
    localparam logic [7:0] IDX_STAT = 8'h23;
    // Configuration bit positions.
    localparam int CFG_BCST_DIS = 0;
    localparam int CFG_UMC_INV = 1;
    localparam int CFG_LB_ANALOG = 2;
    localparam int CFG_LB_START = 3;
    localparam int CFG_SOFT_RST = 4;
    // Reset values, broadcast address and mode subaddresses.
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [31:0] ILL_RST = 32'h0000_0000;
    localparam logic [4:0] BCST_ADDR = 5'h1F;
    localparam logic [4:0] MODE_SA_HI = 5'h1F;
    localparam logic [4:0] MODE_SA_LO = 5'h00;
    // Response kinds.
    typedef enum logic [1:0] {
        RCC_NONE = 2'b00,
        RCC_INFORM = 2'b01,
        RCC_STATUS_ONLY = 2'b10
    } rcc_kind_e;
    // One decoded word from the bus decoder.
    typedef struct packed {
        logic valid;
        logic cmd_sync;
        logic sync_ok;
        logic manch_ok;
        logic bitcnt_ok;
        logic parity;
        logic [15:0] data;
    } rcc_word_s;
    // One classification result.
    typedef struct packed {
        logic valid;
        rcc_kind_e kind;
        logic msg_error;
        logic mode_cmd;
        logic mode_data;
        logic transmit;
        logic pair_receive_flag_rx;
        logic [5:0] count;
        logic [15:0] cmd;
    } rcc_resp_s;
endpackage

// ### hw/rcc_classifier.sv
/*
 * Command word validation and classification with loopback registers.
 * Decides per valid command: in-form answer,
 * status-only answer or silence.
 * Assumes words arrive from a decoder on pclk, registers over APB.
 * Assumes the address pins are static while in use.
 */
module rcc_classifier
(
    // Clock and master reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Terminal address pins, asynchronous.
    input wire logic [4:0] own_addr_pin,
    // Received words.
    input wire rcc_pkg::rcc_word_s rx_word,
    // Classification result, one-cycle valid.
    output rcc_pkg::rcc_resp_s resp,
    // Analog loopback request to the transceiver.
    output logic lb_analog_go,
    output logic [15:0] lb_analog_word
);
    // Address pin synchroniser, two stages.
    logic [4:0] addr_s1;
    logic [4:0] own_addr;
    // Register state. Loopback words and the
    // table clear on master reset only.
    logic [15:0] lb_tx;
    logic [15:0] lb_rx;
    logic bcst_dis;
    logic umc_inv;
    logic lb_analog;
    logic lb_busy;
    logic [6:0] ill_sel;
    // One 32-bit row per {broadcast, T/R, SA}.
    logic [31:0] ill_tab [128];
    // Status kept for later status requests.
    logic msg_err;
    logic [15:0] last_cmd;
    // Held receive command awaiting a possible second word.
    // It may open a pair, so its answer waits
    // for the next word.
    logic pend;
    logic [15:0] pend_cmd;

    // Synchronise the address pins before use.
    // Only the second stage is ever compared.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            addr_s1 <= 5'h00;
            own_addr <= 5'h00;
        end
        else
        begin
            // Two stages; nothing reads the first.
            addr_s1 <= own_addr_pin;
            own_addr <= addr_s1;
        end
    end

    // APB decode; zero wait states.
    // The answer is registered in the setup
    // cycle, so every transfer takes two cycles.
    // Address bits 11:2 pick one aligned word.
    // Upper bits of every register except the table data word read zero.
    wire acc = psel && penable;
    wire wr = acc && pwrite;
    wire [9:0] idx = paddr[11:2];
    wire hit_tx = idx == {2'b00, rcc_pkg::IDX_LB_TX};
    wire hit_rx = idx == {2'b00, rcc_pkg::IDX_LB_RX};
    wire hit_cfg = idx == {2'b00, rcc_pkg::IDX_CFG};
    wire hit_sel = idx == {2'b00, rcc_pkg::IDX_ILL_SEL};
    wire hit_dat = idx == {2'b00, rcc_pkg::IDX_ILL_DAT};
    wire hit_st = idx == {2'b00, rcc_pkg::IDX_STAT};
    wire mapped = hit_tx | hit_rx | hit_cfg | hit_sel | hit_dat | hit_st;
    // Soft reset strobe; clears only status.
    wire soft_rst = wr && hit_cfg && pwdata[rcc_pkg::CFG_SOFT_RST];
    // Read-only receive word refuses writes with an error.
    // Unmapped words answer with an error too.
    wire bad = !mapped || (pwrite && hit_rx);
    // Bit 3 reads back the loopback busy flag.
    wire [31:0] cfg_rd = {27'h0, 1'b0, lb_busy, lb_analog, umc_inv, bcst_dis};
    wire [31:0] st_rd = {15'h0, msg_err, last_cmd};
    // Read multiplexer; unmapped words read zero.
    wire [31:0] rd_mux =
        hit_tx ? {16'h0, lb_tx} :
        hit_rx ? {16'h0, lb_rx} :
        hit_cfg ? cfg_rd :
        hit_sel ? {25'h0, ill_sel} :
        hit_dat ? ill_tab[ill_sel] :
        hit_st ? st_rd : 32'h0000_0000;

    // Bus answer registers. Ready and error stand
    // for exactly one cycle; data reloads every cycle.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Quiet bus answer after reset.
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h0000_0000;
        end
        else
        begin
            // Answer every setup cycle.
            pready <= psel && !penable;
            pslverr <= psel && !penable && bad;
            prdata <= rd_mux;
        end
    end

    // Word validity and command field split.
    // A word counts only with proper sync,
    // clean coding, exact bit count and an odd
    // number of ones over data and parity.
    // Command sync marks a command word.
    wire w_ok = rx_word.valid && rx_word.sync_ok && rx_word.manch_ok
        && rx_word.bitcnt_ok && ((^rx_word.data) ^ rx_word.parity); // R03
    wire w_cmd = w_ok && rx_word.cmd_sync; // R04
    wire [15:0] cw = rx_word.data; // R04
    wire [4:0] c_ta = cw[15:11];
    wire c_tr = cw[10];
    wire [4:0] c_sa = cw[9:5];
    // Own address never matches 31, so a
    // terminal strapped to 31 only hears
    // broadcasts.
    wire c_bc = c_ta == rcc_pkg::BCST_ADDR;
    wire c_own = c_ta == own_addr && !c_bc;
    wire c_mine = c_own || (c_bc && !bcst_dis); // R05 R06
    wire c_mode = c_sa == rcc_pkg::MODE_SA_LO || c_sa == rcc_pkg::MODE_SA_HI; // R08
    // Same decode for the held first word.
    wire p_mode = pend_cmd[9:5] == rcc_pkg::MODE_SA_LO
        || pend_cmd[9:5] == rcc_pkg::MODE_SA_HI;
    wire p_own = pend_cmd[15:11] == own_addr && pend_cmd[15:11] != rcc_pkg::BCST_ADDR;
    wire p_mine = p_own || (pend_cmd[15:11] == rcc_pkg::BCST_ADDR && !bcst_dis);
    // A second command with transmit set completes a pair.
    // A mode subaddress in either half spoils
    // the pair: no answer, no status update.
    wire pair = pend && w_cmd && c_tr; // R19
    wire pair_mode = p_mode || c_mode; // R20

    // Classify one command word: mode, undefined, data word, table bit.
    // Precedence: dropped undefined mode first,
    // then broadcast transmit to a subaddress,
    // then the table bit, which turns an
    // in-form answer into status only.
    function automatic rcc_pkg::rcc_resp_s classify(
        input logic [15:0] c, input logic pair_receive_flag);
        rcc_pkg::rcc_resp_s r;
        logic md;
        logic undef;
        logic ill;
        logic [4:0] lo;
        begin
            r = '0;
            lo = c[4:0];
            md = c[9:5] == rcc_pkg::MODE_SA_LO || c[9:5] == rcc_pkg::MODE_SA_HI; // R08
            // Undefined: MC0..19 set minus 17 receive, 17/20/21 transmit.
            undef = md && ((!c[10] && (!lo[4] || lo == 5'd16 || lo == 5'd18 // R11
                || lo == 5'd19)) || (c[10] && (lo == 5'd17 || lo == 5'd20 // R10
                || lo == 5'd21)));
            // Table bit: row {broadcast, T/R, subaddress}, column low five bits.
            // Each direction of a subaddress has its own row.
            ill = ill_tab[{c[15:11] == rcc_pkg::BCST_ADDR, c[10], c[9:5]}][lo]; // R15 R18
            r.cmd = c;
            r.transmit = c[10]; // R07
            r.mode_cmd = md;
            r.pair_receive_flag_rx = pair_receive_flag; // R21
            // Subaddress: words, zero meaning 32.
            // Mode: its one data word, if any.
            r.count = md ? {5'h00, lo[4]} : (lo == 5'd0 ? 6'd32 : {1'b0, lo}); // R07 R09
            // Codes 16..31 carry one data word,
            // undefined ones included.
            r.mode_data = md && lo[4]; // R09 R13 R17
            // Pick the kind of answer.
            if (undef && umc_inv)
            begin
                r.kind = rcc_pkg::RCC_NONE; // R12
            end
            else if (c[15:11] == rcc_pkg::BCST_ADDR && c[10] && !md)
            begin
                r.kind = rcc_pkg::RCC_NONE; // Broadcast transmit to a subaddress is never valid.
            end
            else if (ill)
            begin
                r.kind = rcc_pkg::RCC_STATUS_ONLY; // R14
                r.msg_error = 1'b1; // R25
                r.mode_data = 1'b0; // R14
                r.count = 6'd0;
            end
            else
            begin
                r.kind = rcc_pkg::RCC_INFORM; // R13
            end
            // Only an answered command is valid.
            r.valid = r.kind != rcc_pkg::RCC_NONE;
            classify = r;
        end
    endfunction

    // Result selection for the current word.
    // A completed pair wins; a held receive
    // command is answered by the next word;
    // a transmit command is answered at once.
    wire rcc_pkg::rcc_resp_s res_pend = classify(pend_cmd, 1'b0);
    wire rcc_pkg::rcc_resp_s res_now = classify(cw, 1'b0);
    wire rcc_pkg::rcc_resp_s res_pair_receive_flag = classify(pend_cmd, 1'b1);
    wire rcc_pkg::rcc_resp_s res_ptx = classify(cw, 1'b0);
    // As second word of a pair only the own
    // address transmits, never broadcast.
    wire c_tx2 = c_own; // R19 R22
    wire rcc_pkg::rcc_resp_s next_resp =
        !rx_word.valid ? '0 :
        pair ? (pair_mode ? '0 : // R20
            p_mine ? res_pair_receive_flag : // R21
            c_tx2 ? res_ptx : '0) : // R22
        pend ? (p_mine ? res_pend : '0) :
        (w_cmd && c_mine && c_tr) ? res_now : '0; // R05 R06
    // A receive command is held one word to see whether a pair follows.
    // Transmit, data word or pair clears it.
    wire next_pend = w_cmd && !c_tr && !pair;

    // Command tracking, status and result output.
    // Status follows every answered command;
    // an answer beats a soft reset in the same
    // cycle so no answered command is lost.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Nothing held after reset.
            pend <= 1'b0;
            pend_cmd <= rcc_pkg::WORD_RST;
            resp <= '0;
            msg_err <= 1'b0;
            last_cmd <= rcc_pkg::WORD_RST;
        end
        else
        begin
            // The result stands for one cycle only.
            resp <= next_resp;
            // Every decoded word moves the tracker on.
            if (rx_word.valid)
            begin
                pend <= next_pend;
                pend_cmd <= cw;
            end
            if (next_resp.valid)
            begin
                // An answered command sets the status.
                msg_err <= next_resp.msg_error; // R13 R14 R25
                last_cmd <= next_resp.cmd;
            end
            else if (soft_rst)
            begin
                // Soft reset clears the status only.
                msg_err <= 1'b0;
                last_cmd <= rcc_pkg::WORD_RST;
            end
        end
    end

    // Configuration and illegal table select.
    // Start and soft reset are strobes and are
    // never stored; bit 3 reads the busy flag.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Broadcast on, undefined valid by default.
            bcst_dis <= 1'b0;
            umc_inv <= 1'b0; // R12
            lb_analog <= 1'b0;
            ill_sel <= 7'h00;
        end
        else if (wr && hit_cfg)
        begin
            // Plain stored bits.
            bcst_dis <= pwdata[rcc_pkg::CFG_BCST_DIS];
            umc_inv <= pwdata[rcc_pkg::CFG_UMC_INV];
            lb_analog <= pwdata[rcc_pkg::CFG_LB_ANALOG];
        end
        else if (wr && hit_sel)
        begin
            // Row select for the table data word.
            ill_sel <= pwdata[6:0];
        end
    end

    // Illegal table, cleared by master reset only.
    // All zero means every valid command gets
    // an in-form answer; set bits make chosen
    // commands answer with status only.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            for (int i = 0; i < 128; i++)
            begin
                // Every row cleared.
                ill_tab[i] <= rcc_pkg::ILL_RST; // R16
            end
        end
        else if (wr && hit_dat)
        begin
            // Whole row written at once.
            ill_tab[ill_sel] <= pwdata;
        end
    end

    // Digital loopback: encode with odd parity, decode, check, store.
    // Nothing reaches the transceiver; the word
    // lands in the receive register at once.
    wire [16:0] enc = {lb_tx, ~(^lb_tx)}; // R24
    wire dec_ok = ^enc; // R24
    // Start strobe: config write with bit 3.
    wire lb_go = wr && hit_cfg && pwdata[rcc_pkg::CFG_LB_START];

    // Loopback registers; soft reset leaves them alone.
    // An analog test hands the word to the
    // transceiver and stays busy until the next
    // decoded word, stored as received word.
    // Hazard: with no word back it stays busy.
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            // Master reset clears both test words.
            lb_tx <= rcc_pkg::WORD_RST; // R01
            lb_rx <= rcc_pkg::WORD_RST; // R02
            lb_busy <= 1'b0;
            lb_analog_go <= 1'b0;
            lb_analog_word <= rcc_pkg::WORD_RST;
        end
        else
        begin
            // One-cycle request to the transceiver.
            lb_analog_go <= lb_go && pwdata[rcc_pkg::CFG_LB_ANALOG]; // R23
            lb_analog_word <= lb_tx;
            // Host write of the transmit word.
            if (wr && hit_tx)
            begin
                lb_tx <= pwdata[15:0]; // R01
            end
            // Digital test stores the word at once.
            if (lb_go && !pwdata[rcc_pkg::CFG_LB_ANALOG])
            begin
                if (dec_ok)
                begin
                    lb_rx <= enc[16:1]; // R23 R24
                end
            end
            else if (lb_go)
            begin
                lb_busy <= 1'b1;
            end
            else if (lb_busy && rx_word.valid)
            begin
                lb_rx <= rx_word.data; // R23
                lb_busy <= 1'b0;
            end
        end
    end
endmodule

// ### dv/rcc_checker.sv
/*
 * Port assertions for the command classifier.
 * Assumes it is bound onto rcc_classifier and shares its clock and reset.
 */
module rcc_checker
(
    // Clock and master reset.
    input wire logic pclk,
    input wire logic presetn,
    // APB slave side.
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [11:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    // Word path and loopback.
    input wire logic [4:0] own_addr_pin,
    input wire rcc_pkg::rcc_word_s rx_word,
    input wire rcc_pkg::rcc_resp_s resp,
    input wire logic lb_analog_go,
    input wire logic [15:0] lb_analog_word
);
    // Every check runs on pclk and is quiet during master reset.
    default clocking @(posedge pclk); endclocking
    default disable iff (!presetn);

    property p_ready; psel && !penable |=> pready; endproperty
    a_ready: assert property (p_ready) else $error("no wait-free answer");
    property p_err; pslverr |-> pready; endproperty
    a_err: assert property (p_err) else $error("error without ready");
    property p_rxro; psel && !penable && pwrite && paddr == 12'h064 |=> pslverr; endproperty
    a_rxro: assert property (p_rxro) else $error("receive word accepted a write");
    property p_ill; resp.valid && resp.kind == rcc_pkg::RCC_STATUS_ONLY |-> resp.msg_error;
    endproperty
    a_ill: assert property (p_ill) else $error("status-only without error");
    property p_legal; resp.valid && resp.kind == rcc_pkg::RCC_INFORM |-> !resp.msg_error;
    endproperty
    a_legal: assert property (p_legal) else $error("in-form answer flags error");
    property p_mode; resp.valid |-> resp.mode_cmd == (resp.cmd[9:5] inside {5'h00, 5'h1F});
    endproperty
    a_mode: assert property (p_mode) else $error("mode decode wrong");
    property p_cnt; resp.valid && !resp.mode_cmd && resp.kind == rcc_pkg::RCC_INFORM
        |-> resp.count == {resp.cmd[4:0] == 5'h00, resp.cmd[4:0]}; endproperty
    a_cnt: assert property (p_cnt) else $error("word count wrong");
    property p_mdat; resp.valid && resp.mode_cmd && resp.kind == rcc_pkg::RCC_INFORM
        |-> resp.mode_data == resp.cmd[4] && resp.count == {5'h00, resp.cmd[4]}; endproperty
    a_mdat: assert property (p_mdat) else $error("mode data word wrong");
    property p_dig; psel && penable && pready && pwrite && paddr == 12'h080 && pwdata[3]
        && !pwdata[2] |=> !lb_analog_go; endproperty
    a_dig: assert property (p_dig) else $error("digital loopback drove the bus");
    property p_src; resp.valid |-> $past(rx_word.valid); endproperty
    a_src: assert property (p_src) else $error("result without a word");
    property p_dir; resp.valid |-> resp.transmit == resp.cmd[10]; endproperty
    a_dir: assert property (p_dir) else $error("direction bit wrong");
endmodule

bind rcc_classifier rcc_checker rcc_checker_i (.pclk(pclk), .presetn(presetn), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .own_addr_pin(own_addr_pin), .rx_word(rx_word),
    .resp(resp), .lb_analog_go(lb_analog_go), .lb_analog_word(lb_analog_word));

// ### dv/rcc_bc_model.sv
/*
 * Behavioural bus controller plus word decoder feeding the classifier.
 * Assumes the bench calls send, which keeps word order as commanded.
 */
module rcc_bc_model
(
    // Clock.
    input wire logic pclk,
    // Decoded word towards the classifier.
    output rcc_pkg::rcc_word_s rx_word
);
    timeunit 1ns;
    timeprecision 1ns;

    // Bus is quiet until the first word.
    initial rx_word = '0;

    // One word for one cycle; bad spoils its parity on purpose.
    task automatic send(input logic [15:0] d, input logic cs, input logic bad);
        @(posedge pclk);
        rx_word <= {1'b1, cs, 3'b111, ~^d ^ bad, d};
        @(posedge pclk);
        // Released word shows inverted data so nothing stale looks valid.
        rx_word <= {1'b0, ~cs, 4'h0, ~d};
    endtask
endmodule

// ### dv/tb.sv
/*
 * Self-checking bench for the command classifier.
 * Assumes the checker is bound in and the terminal address is 5.
 */
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic pclk = 1'b0;
    logic presetn, psel, penable, pwrite, pready, pslverr, lb_analog_go, err;
    logic [11:0] paddr;
    logic [31:0] pwdata, prdata, rd;
    logic [4:0] own_addr_pin;
    logic [15:0] lb_analog_word;
    rcc_pkg::rcc_word_s rx_word;
    rcc_pkg::rcc_resp_s resp, r;
    int err_count = 0;
    int checks_done = 0;

    rcc_classifier rcc_classifier_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .own_addr_pin(own_addr_pin), .rx_word(rx_word),
        .resp(resp), .lb_analog_go(lb_analog_go), .lb_analog_word(lb_analog_word));
    rcc_bc_model rcc_bc_model_i (.pclk(pclk), .rx_word(rx_word));

    // Clock of 20 ns period.
    always #10 pclk = ~pclk;

    // Prints the verdict and stops.
    task automatic end_of_test;
        if (err_count == 0 && checks_done > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask

    // Compares one value against its expectation.
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            err_count++;
            $display("mismatch at %0t: got %h want %h", $time, got, exp);
        end
    endtask

    // One APB transfer; read data and error land in rd and err.
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int i;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        for (i = 0; i < 8 && pready !== 1'b1; i++) @(posedge pclk);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        if (i == 8)
        begin
            chk(32'h0, 32'h1);
            end_of_test();
        end
    endtask

    // Sends a word and captures any result inside a short window.
    task automatic tx(input logic [15:0] d, input logic cs, input logic bad);
        rcc_bc_model_i.send(d, cs, bad);
        r = '0;
        repeat (4)
        begin
            @(negedge pclk);
            if (resp.valid === 1'b1)
                r = resp;
        end
    endtask

    // Packs the captured result and builds an expected in-form one.
    function automatic logic [31:0] pk();
        return 32'({r.valid, r.kind, r.msg_error, r.mode_data, r.pair_receive_flag_rx, r.count});
    endfunction
    function automatic logic [31:0] want(input logic [2:0] f, input logic [5:0] c);
        return 32'({3'b101, f, c});
    endfunction

    // Register reset values and access kinds.
    task automatic t_regs;
        apb(1'b0, 12'h060, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h088, 32'h0);
        chk(rd, 32'h0);
        apb(1'b1, 12'h060, 32'h0000A5C3);
        apb(1'b0, 12'h060, 32'h0);
        chk(rd, 32'h0000A5C3);
        apb(1'b1, 12'h064, 32'h00001111);
        chk(32'(err), 32'h1);
        apb(1'b0, 12'h064, 32'h0);
        chk(rd, 32'h0);
        apb(1'b0, 12'h0FC, 32'h0);
        chk(32'(err), 32'h1);
    endtask

    // Digital loopback, soft reset, then analog loopback over the model.
    task automatic t_loop;
        int i;
        apb(1'b1, 12'h080, 32'h08);
        apb(1'b0, 12'h064, 32'h0);
        chk(rd, 32'h0000A5C3);
        apb(1'b1, 12'h080, 32'h10);
        apb(1'b0, 12'h060, 32'h0);
        chk(rd, 32'h0000A5C3);
        apb(1'b1, 12'h080, 32'h0C);
        for (i = 0; i < 8 && lb_analog_go !== 1'b1; i++) @(negedge pclk);
        if (i == 8)
        begin
            chk(32'h0, 32'h1);
            end_of_test();
        end
        chk(32'(lb_analog_word), 32'h0000A5C3);
        rcc_bc_model_i.send(16'h3C96, 1'b0, 1'b0);
        apb(1'b0, 12'h064, 32'h0);
        chk(rd, 32'h00003C96);
    endtask

    // Broadcast disable and undefined-invalid drop commands silently.
    task automatic t_config;
        apb(1'b1, 12'h080, 32'h03);
        tx({5'h1F, 1'b1, 5'h00, 5'h01}, 1'b1, 1'b0);
        chk(pk(), 32'h0);
        tx({5'h05, 1'b1, 5'h1F, 5'h11}, 1'b1, 1'b0);
        chk(pk(), 32'h0);
        tx({5'h05, 1'b1, 5'h00, 5'h14}, 1'b1, 1'b0);
        chk(pk(), 32'h0);
        apb(1'b1, 12'h080, 32'h00);
    endtask

    // Validity, addressing and classification with default settings.
    task automatic t_classify;
        tx({5'h05, 1'b1, 5'h03, 5'h00}, 1'b1, 1'b0);
        chk(pk(), want(3'b000, 6'd32));
        tx({5'h05, 1'b1, 5'h03, 5'h07}, 1'b1, 1'b1);
        chk(pk(), 32'h0);
        tx({5'h06, 1'b1, 5'h03, 5'h07}, 1'b1, 1'b0);
        chk(pk(), 32'h0);
        tx(16'h1234, 1'b0, 1'b0);
        chk(pk(), 32'h0);
        tx({5'h05, 1'b1, 5'h1F, 5'h11}, 1'b1, 1'b0);
        chk(pk(), want(3'b010, 6'd1));
        tx({5'h05, 1'b1, 5'h00, 5'h02}, 1'b1, 1'b0);
        chk(pk(), want(3'b000, 6'd0));
        tx({5'h05, 1'b1, 5'h00, 5'h19}, 1'b1, 1'b0);
        chk(pk(), want(3'b010, 6'd1));
        tx({5'h1F, 1'b1, 5'h00, 5'h01}, 1'b1, 1'b0);
        chk(pk(), want(3'b000, 6'd0));
    endtask

    // An illegal table entry gives status only and sets message error.
    task automatic t_illegal;
        apb(1'b1, 12'h084, 32'h23);
        apb(1'b1, 12'h088, 32'h1);
        tx({5'h05, 1'b1, 5'h03, 5'h00}, 1'b1, 1'b0);
        chk(32'({r.valid, r.kind, r.msg_error}), 32'hD);
        apb(1'b0, 12'h08C, 32'h0);
        chk(32'(rd[16]), 32'h1);
        tx({5'h05, 1'b1, 5'h03, 5'h01}, 1'b1, 1'b0);
        chk(pk(), want(3'b000, 6'd1));
        apb(1'b1, 12'h088, 32'h0);
    endtask

    // Pair handling: own receive, mode pair refused, own transmit.
    task automatic t_pair_receive_flag;
        tx({5'h05, 1'b0, 5'h02, 5'h04}, 1'b1, 1'b0);
        chk(pk(), 32'h0);
        tx({5'h06, 1'b1, 5'h02, 5'h04}, 1'b1, 1'b0);
        chk(pk(), want(3'b001, 6'd4));
        chk(32'(r.cmd), 32'h2844);
        tx({5'h05, 1'b0, 5'h02, 5'h04}, 1'b1, 1'b0);
        tx({5'h06, 1'b1, 5'h00, 5'h04}, 1'b1, 1'b0);
        chk(pk(), 32'h0);
        tx({5'h06, 1'b0, 5'h02, 5'h04}, 1'b1, 1'b0);
        tx({5'h05, 1'b1, 5'h02, 5'h04}, 1'b1, 1'b0);
        chk(pk(), want(3'b000, 6'd4));
    endtask

    // Reset for four cycles, then every scenario in turn.
    initial
    begin
        presetn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 12'h000;
        pwdata = 32'h0;
        own_addr_pin = 5'h05;
        repeat (4) @(posedge pclk);
        presetn <= 1'b1;
        t_regs();
        t_loop();
        t_config();
        t_classify();
        t_illegal();
        t_pair_receive_flag();
        end_of_test();
    end
endmodule
